// ---- rtl/cd_command_decoder.sv ----
// Design decision made here: register access over Wishbone.
`default_nettype none
module cd_command_decoder
#(
    parameter logic [15:0] DIV_RESET = cd_pkg::DIV_RESET
)
(
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [cd_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire logic [2:0]                gatePin,
    output logic      [2:0]                counterOut
);
    localparam int N = cd_pkg::NUM_CNT;

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave

    logic        req;
    logic        wrLane;
    logic [7:0]  wordIdx;
    logic        cmdWrite;
    logic        divWrite;
    logic [N-1:0] dataWrite;
    logic [N-1:0] dataRead;
    logic [31:0] next_datOut;
    logic        next_ack;

    // ack is a single registered pulse, so one access per request
    assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrLane  = req & wb_we_i & wb_sel_i[0];
    assign wordIdx = wb_adr_i[cd_pkg::ADDR_W-1:2];
    assign cmdWrite = wrLane && (wordIdx == cd_pkg::IDX_CMD);
    assign divWrite = wrLane && (wordIdx == cd_pkg::IDX_DIV);
    assign next_ack = req;

    ////////////////////////////////////////////////////////////////////////////////
    // command fields

    logic [1:0] cmdSel;
    logic [1:0] cmdRw;
    logic [2:0] cmdMode;
    logic       cmdBcd;
    logic       isReadback;
    logic       rbCountN;
    logic       rbStatusN;
    logic [2:0] rbMask;

    assign cmdSel     = wb_dat_i[cd_pkg::CMD_SEL +: 2];
    assign cmdRw      = wb_dat_i[cd_pkg::CMD_RW +: 2];
    assign cmdMode    = wb_dat_i[cd_pkg::CMD_MODE +: 3];
    assign cmdBcd     = wb_dat_i[cd_pkg::CMD_BCD];
    assign isReadback = (cmdSel == cd_pkg::SEL_READBACK);
    assign rbCountN   = wb_dat_i[cd_pkg::RB_COUNT_N];
    assign rbStatusN  = wb_dat_i[cd_pkg::RB_STAT_N];
    // bit 0 of a read-back is left unread; the host keeps it zero
    assign rbMask     = wb_dat_i[cd_pkg::RB_MASK +: 3];

    ////////////////////////////////////////////////////////////////////////////////
    // gate pins and count tick

    logic [2:0]  gateS1;
    logic [2:0]  gateS2;
    logic [2:0]  gateS3;
    logic [2:0]  gateLevel;
    logic [2:0]  gatePrev;
    logic [2:0]  next_gateLevel;
    logic [2:0]  gateRise;
    logic [15:0] divValue;
    logic [15:0] divCount;
    logic [15:0] next_divValue;
    logic [15:0] next_divCount;
    logic        tick;

    // level moves only when the last two stages agree
    assign next_gateLevel = (gateS2 & gateS3) | (gateLevel & (gateS2 | gateS3));
    assign gateRise       = gateLevel & ~gatePrev;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            gateS1    <= 3'h0;
            gateS2    <= 3'h0;
            gateS3    <= 3'h0;
            gateLevel <= 3'h0;
            gatePrev  <= 3'h0;
        end
        else
        begin
            gateS1    <= gatePin;
            gateS2    <= gateS1;
            gateS3    <= gateS2;
            gateLevel <= next_gateLevel;
            gatePrev  <= gateLevel;
        end
    end

    assign tick = (divCount == divValue);

    always_comb
    begin
        next_divCount = tick ? 16'h0000 : divCount + 16'h0001;
        next_divValue = divValue;
        if (divWrite)
        begin
            next_divValue = {wb_sel_i[1] ? wb_dat_i[15:8] : divValue[15:8], wb_dat_i[7:0]};
            next_divCount = 16'h0000;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            divCount <= 16'h0000;
            divValue <= DIV_RESET;
        end
        else
        begin
            divCount <= next_divCount;
            divValue <= next_divValue;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per counter latches and byte sequencing

    cd_pkg::cd_chan_type chan      [N];
    cd_pkg::cd_chan_type next_chan [N];
    logic [7:0]          readByte  [N];
    logic [15:0]         engCount  [N];
    logic [N-1:0]        engOut;
    logic [N-1:0]        engLoaded;
    logic [N-1:0]        countLatchedV;
    logic [N-1:0]        statusLatchedV;
    logic [N-1:0]        nullV;

    generate
        for (genvar i = 0; i < N; i++)
        begin : g_chan
            logic        ctrlHit;
            logic        latchHit;
            logic        statHit;
            logic        hiSel;
            logic [15:0] src;
            logic        loadStrobe;
            logic [15:0] loadValue;
            logic [2:0]  engMode;

            assign dataWrite[i] = wrLane && (wordIdx == cd_pkg::IDX_DATA[i]);
            assign dataRead[i]  = req && !wb_we_i && (wordIdx == cd_pkg::IDX_DATA[i]);
            assign ctrlHit  = cmdWrite && !isReadback && (cmdSel == 2'(i)) &&
                              (cmdRw != cd_pkg::RW_LATCH);
            assign latchHit = cmdWrite && ((!isReadback && (cmdSel == 2'(i)) &&
                              (cmdRw == cd_pkg::RW_LATCH)) ||
                              (isReadback && rbMask[i] && !rbCountN));
            assign statHit  = cmdWrite && isReadback && rbMask[i] && !rbStatusN;
            assign hiSel    = (chan[i].rw == cd_pkg::RW_HIGH) ||
                              ((chan[i].rw == cd_pkg::RW_BOTH) && chan[i].readHigh);
            assign src      = chan[i].countLatched ? chan[i].latch : engCount[i];
            assign engMode  = ctrlHit ? cmdMode : chan[i].mode;

            always_comb
            begin
                next_chan[i] = chan[i];
                loadStrobe = 1'b0;
                loadValue = 16'h0000;
                readByte[i] = chan[i].statusLatched ? chan[i].status :
                              (hiSel ? src[15:8] : src[7:0]);
                if (engLoaded[i])
                    next_chan[i].nullFlag = 1'b0;
                if (ctrlHit)
                begin
                    next_chan[i].rw = cmdRw;
                    next_chan[i].mode = cmdMode;
                    next_chan[i].decimal = cmdBcd;
                    next_chan[i].writeHigh = 1'b0;
                    next_chan[i].readHigh = 1'b0;
                    next_chan[i].nullFlag = 1'b1;
                end
                if (latchHit && !chan[i].countLatched)
                begin
                    next_chan[i].countLatched = 1'b1;
                    next_chan[i].latch = engCount[i];
                end
                if (statHit && !chan[i].statusLatched)
                begin
                    next_chan[i].statusLatched = 1'b1;
                    next_chan[i].status = {engOut[i], chan[i].nullFlag, chan[i].rw,
                                           chan[i].mode, chan[i].decimal};
                end
                if (dataRead[i])
                begin
                    if (chan[i].statusLatched)
                        next_chan[i].statusLatched = 1'b0;
                    else
                    begin
                        if (chan[i].rw == cd_pkg::RW_BOTH)
                            next_chan[i].readHigh = ~chan[i].readHigh;
                        if (chan[i].rw != cd_pkg::RW_BOTH || chan[i].readHigh)
                            next_chan[i].countLatched = 1'b0;
                    end
                end
                if (dataWrite[i])
                begin
                    unique case (chan[i].rw)
                        cd_pkg::RW_HIGH:
                        begin
                            loadStrobe = 1'b1;
                            loadValue = {wb_dat_i[7:0], 8'h00};
                        end
                        cd_pkg::RW_BOTH:
                        begin
                            next_chan[i].writeHigh = ~chan[i].writeHigh;
                            next_chan[i].stage = wb_dat_i[7:0];
                            loadStrobe = chan[i].writeHigh;
                            loadValue = {wb_dat_i[7:0], chan[i].stage};
                        end
                        default:
                        begin
                            loadStrobe = 1'b1;
                            loadValue = {8'h00, wb_dat_i[7:0]};
                        end
                    endcase
                    if (loadStrobe)
                        next_chan[i].nullFlag = 1'b1;
                end
            end

            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                    chan[i] <= cd_pkg::CHAN_RESET;
                else
                    chan[i] <= next_chan[i];
            end

            cd_count_engine cd_count_engine_i
            (
                .clk        (clk),
                .reset      (reset),
                .tick       (tick),
                .gateLevel  (gateLevel[i]),
                .gateRise   (gateRise[i]),
                .ctrlWrite  (ctrlHit),
                .mode       (engMode),
                .decimal    (chan[i].decimal),
                .loadStrobe (loadStrobe),
                .loadValue  (loadValue),
                .count      (engCount[i]),
                .outLevel   (engOut[i]),
                .loadDone   (engLoaded[i])
            );

            assign countLatchedV[i]  = chan[i].countLatched;
            assign statusLatchedV[i] = chan[i].statusLatched;
            assign nullV[i]          = chan[i].nullFlag;
        end
    endgenerate

    assign counterOut = engOut;

    ////////////////////////////////////////////////////////////////////////////////
    // read data

    always_comb
    begin
        next_datOut = 32'h0000_0000;
        if (req && !wb_we_i)
        begin
            // the command port reads as zero; it holds nothing readable
            if (dataRead[0])
                next_datOut = {24'h00_0000, readByte[0]};
            else if (dataRead[1])
                next_datOut = {24'h00_0000, readByte[1]};
            else if (dataRead[2])
                next_datOut = {24'h00_0000, readByte[2]};
            else if (wordIdx == cd_pkg::IDX_STAT)
                next_datOut = {17'h0_0000, statusLatchedV, 1'b0, countLatchedV,
                               1'b0, nullV, 1'b0, engOut};
            else if (wordIdx == cd_pkg::IDX_DIV)
                next_datOut = {16'h0000, divValue};
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_datOut;
        end
    end
endmodule : cd_command_decoder
`default_nettype wire

// ---- rtl/cd_count_engine.sv ----
`default_nettype none
module cd_count_engine
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        tick,
    input  wire logic        gateLevel,
    input  wire logic        gateRise,
    input  wire logic        ctrlWrite,
    input  wire logic [2:0]  mode,
    input  wire logic        decimal,
    input  wire logic        loadStrobe,
    input  wire logic [15:0] loadValue,
    output logic      [15:0] count,
    output logic             outLevel,
    output logic             loadDone
);
    cd_pkg::cd_engine_type eng;
    cd_pkg::cd_engine_type next_eng;
    logic [2:0]            effMode;
    logic                  hwMode;

    function automatic logic [15:0] decrement(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic        borrow;
        r = v - 16'h0001;
        borrow = 1'b1;
        if (bcd)
        begin
            r = v;
            for (int n = 0; n < 4; n++)
            begin
                if (borrow)
                begin
                    if (v[4*n +: 4] == 4'h0)
                        r[4*n +: 4] = 4'h9;
                    else
                    begin
                        r[4*n +: 4] = v[4*n +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : decrement

    // codes 6 and 7 alias the rate and square modes
    assign effMode = (mode[2] && mode[1]) ? {1'b0, mode[1:0]} : mode;
    assign hwMode  = (effMode == cd_pkg::MODE_ONESHOT) || (effMode == cd_pkg::MODE_HW_STROBE);

    always_comb
    begin
        next_eng = eng;
        next_eng.loaded = 1'b0;
        if (gateRise)
            next_eng.trigger = 1'b1;
        if (ctrlWrite)
        begin
            next_eng = cd_pkg::ENGINE_RESET;
            next_eng.out = (effMode != cd_pkg::MODE_TERMINAL);
        end
        else if (loadStrobe)
        begin
            next_eng.reload  = loadValue;
            next_eng.pending = 1'b1;
            if (effMode == cd_pkg::MODE_TERMINAL)
                next_eng.out = 1'b0;
        end
        else if (tick)
        begin
            if ((eng.pending || (hwMode && eng.running)) && (!hwMode || eng.trigger))
            begin
                next_eng.count   = eng.pending ? eng.reload : eng.reload;
                next_eng.pending = 1'b0;
                next_eng.running = 1'b1;
                next_eng.trigger = 1'b0;
                next_eng.loaded  = eng.pending;
                next_eng.out     = !(effMode == cd_pkg::MODE_TERMINAL ||
                                     effMode == cd_pkg::MODE_ONESHOT);
            end
            else if (hwMode && eng.trigger && !eng.pending)
            begin
                // retrigger after the count has expired
                next_eng.count   = eng.reload;
                next_eng.running = 1'b1;
                next_eng.trigger = 1'b0;
                next_eng.out     = (effMode != cd_pkg::MODE_ONESHOT);
            end
            else if (eng.running && (hwMode || gateLevel))
            begin
                next_eng.count = decrement(eng.count, decimal);
                if (eng.count == 16'h0001)
                begin
                    unique case (effMode)
                        cd_pkg::MODE_TERMINAL: next_eng.out = 1'b1;
                        cd_pkg::MODE_ONESHOT:
                        begin
                            next_eng.out = 1'b1;
                            next_eng.running = 1'b0;
                        end
                        cd_pkg::MODE_RATE:
                        begin
                            next_eng.out = 1'b0;
                            next_eng.count = eng.reload;
                        end
                        cd_pkg::MODE_SQUARE:
                        begin
                            next_eng.out = ~eng.out;
                            next_eng.count = eng.reload;
                        end
                        default:
                        begin
                            next_eng.out = 1'b0;
                            next_eng.running = 1'b0;
                        end
                    endcase
                end
                else if (effMode != cd_pkg::MODE_SQUARE && effMode != cd_pkg::MODE_TERMINAL)
                    next_eng.out = (effMode == cd_pkg::MODE_ONESHOT) ? eng.out : 1'b1;
            end
            else if (effMode == cd_pkg::MODE_SW_STROBE || effMode == cd_pkg::MODE_HW_STROBE)
                next_eng.out = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            eng <= cd_pkg::ENGINE_RESET;
        else
            eng <= next_eng;
    end

    assign count    = eng.count;
    assign outLevel = eng.out;
    assign loadDone = eng.loaded;
endmodule : cd_count_engine
`default_nettype wire

// ---- rtl/cd_pkg.sv ----
// What this block does
// - write-only 8-bit command port at 1E
// - bits 7-6 pick counter or read-back
// - bits 5-4 pick latch or byte order
// - count latch freezes count for next read
// - bits 3-1 pick one of six modes
// - bit 0 selects decimal, else 16-bit binary
// - bits 7-6 both set means read-back
// - read-back bit 5 low latches counts
// - read-back bit 4 low latches status
// - read-back bits 3-1 pick counters three..one
// - status byte: out, null, order, mode, decimal
// - after init both counters' outputs high
// - only first latch counts until read
// - latched count read low byte then high
// - status read first, then count bytes
`default_nettype none
package cd_pkg;
    localparam int         NUM_CNT = 3;
    localparam int         ADDR_W  = 10;
    // register indices; byte address is index times four
    localparam logic [2:0][7:0] IDX_DATA = {8'h1c, 8'h1a, 8'h18};
    localparam logic [7:0] IDX_CMD  = 8'h1e;
    localparam logic [7:0] IDX_STAT = 8'h1f;
    localparam logic [7:0] IDX_DIV  = 8'h20;
    localparam int         CMD_SEL    = 6;
    localparam int         CMD_RW     = 4;
    localparam int         CMD_MODE   = 1;
    localparam int         CMD_BCD    = 0;
    localparam int         RB_COUNT_N = 5;
    localparam int         RB_STAT_N  = 4;
    localparam int         RB_MASK    = 1;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] RW_LATCH = 2'h0;
    localparam logic [1:0] RW_LOW   = 2'h1;
    localparam logic [1:0] RW_HIGH  = 2'h2;
    localparam logic [1:0] RW_BOTH  = 2'h3;
    localparam logic [2:0] MODE_TERMINAL  = 3'h0;
    localparam logic [2:0] MODE_ONESHOT   = 3'h1;
    localparam logic [2:0] MODE_RATE      = 3'h2;
    localparam logic [2:0] MODE_SQUARE    = 3'h3;
    localparam logic [2:0] MODE_SW_STROBE = 3'h4;
    localparam logic [2:0] MODE_HW_STROBE = 3'h5;
    localparam logic [15:0] DIV_RESET = 16'h007c;

    typedef struct packed {
        logic [1:0]  rw;
        logic [2:0]  mode;
        logic        decimal;
        logic        nullFlag;
        logic        writeHigh;
        logic        readHigh;
        logic [7:0]  stage;
        logic        countLatched;
        logic [15:0] latch;
        logic        statusLatched;
        logic [7:0]  status;
    } cd_chan_type;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] reload;
        logic        out;
        logic        pending;
        logic        running;
        logic        trigger;
        logic        loaded;
    } cd_engine_type;

    localparam cd_chan_type CHAN_RESET = '0;
    localparam cd_engine_type ENGINE_RESET = '0;
endpackage : cd_pkg
`default_nettype wire

// ---- tb/cd_command_decoder_assertions.sv ----
`default_nettype none
module cd_command_decoder_assertions
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [2:0]  counterOut
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    logic req;
    logic cmdWr;
    logic [7:0] cw;
    assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cmdWr = req && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == cd_pkg::IDX_CMD;
    assign cw    = wb_dat_i[7:0];
    ////////////////////////////////////////////////////////////////////////
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    AST_ACK_ANSWER: assert property (req |=> wb_ack_o)
        else $error("request not answered next cycle");
    AST_ACK_CAUSE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    AST_CMD_READS_ZERO: assert property (req && !wb_we_i && wb_adr_i[9:2] == cd_pkg::IDX_CMD
        |=> wb_dat_o == 32'h0) else $error("command port read not zero");
    AST_INIT_FIRST_HIGH: assert property (cmdWr && cw == 8'h14 |-> ##3 counterOut[0])
        else $error("first counter output not high");
    AST_INIT_SECOND_HIGH: assert property (cmdWr && cw == 8'h54 |-> ##3 counterOut[1])
        else $error("second counter output not high");
    AST_MODE0_OUT_LOW: assert property (cmdWr && cw[7:6] == 2'h2 && cw[5:4] != 2'h0
        && cw[3:1] == 3'h0 |-> ##3 !counterOut[2]) else $error("mode 0 output not low");
    AST_MODEX_OUT_HIGH: assert property (cmdWr && cw[7:6] == 2'h2 && cw[5:4] != 2'h0
        && cw[3:1] != 3'h0 |-> ##3 counterOut[2]) else $error("output not high");
    cover property (cmdWr && cw[7:6] == 2'h3);
    cover property (cmdWr && cw == 8'h54);
    cover property (req && !wb_we_i && wb_adr_i[9:2] == cd_pkg::IDX_DATA[0]);
endmodule : cd_command_decoder_assertions
bind cd_command_decoder cd_command_decoder_assertions cd_command_decoder_assertions_i
    (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
     .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
     .wb_ack_o(wb_ack_o), .counterOut(counterOut));
`default_nettype wire

// ---- tb/cd_command_decoder_tb.sv ----
`default_nettype none
module cd_command_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] CMD = 10'h078;
    localparam logic [9:0] ST  = 10'h07c;
    logic        clk;
    logic        reset;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        ack;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [2:0]  gatePin;
    logic [2:0]  counterOut;
    int          numErrors = 0;
    int          samplesChecked = 0;
    logic [15:0] v1;
    logic [15:0] v2;
    cd_host_model cd_host_model_i (.clk(clk), .ack(ack), .datIn(rdat), .cyc(cyc), .stb(stb),
        .we(we), .adr(adr), .sel(sel), .datOut(wdat));
    cd_command_decoder cd_command_decoder_i (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .gatePin(gatePin), .counterOut(counterOut));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samplesChecked++;
        if (g !== e)
        begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd16(input logic [9:0] a, output logic [15:0] v);
        cd_host_model_i.rd(a, v[7:0]);
        cd_host_model_i.rd(a, v[15:8]);
    endtask : rd16
    task automatic printVerdict();
        $display("checks %0d errors %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : printVerdict
    ////////////////////////////////////////////////////////////////////////
    task automatic testInit();
        logic [7:0] d;
        cd_host_model_i.init();
        repeat (3) @(posedge clk);
        chk("init outputs", 16'h3, {14'h0, counterOut[1:0]});
        cd_host_model_i.rd(CMD, d);
        chk("command read", 16'h0, {8'h0, d});
    endtask : testInit
    task automatic testLatch();
        logic [7:0] d;
        // slow ticks keep the count nearly still while it is read
        cd_host_model_i.wr(10'h080, 16'h00ff);
        cd_host_model_i.wr(CMD, 16'h0034);
        cd_host_model_i.wr(10'h060, 16'h0034);
        cd_host_model_i.wr(10'h060, 16'h0012);
        cd_host_model_i.rd(ST, d);
        chk("null set", 16'h1, {15'h0, d[4]});
        repeat (200)
        begin
            cd_host_model_i.rd(ST, d);
            if (d[4] === 1'b0)
                break;
        end
        chk("null cleared", 16'h0, {15'h0, d[4]});
        cd_host_model_i.wr(CMD, 16'h0000);
        repeat (600) @(posedge clk);
        cd_host_model_i.wr(CMD, 16'h0000);
        rd16(10'h060, v1);
        chk("first latch", 16'h1, {15'h0, v1 >= 16'h1233 && v1 <= 16'h1234});
        cd_host_model_i.wr(CMD, 16'h0000);
        rd16(10'h060, v2);
        chk("second latch", 16'h1, {15'h0, v2 + 16'h2 <= v1 && v2 + 16'h5 >= v1});
    endtask : testLatch
    task automatic testReadBack();
        logic [7:0] d;
        cd_host_model_i.wr(CMD, 16'h00c2);
        cd_host_model_i.rd(10'h060, d);
        chk("status first", 16'h34, {9'h0, d[6:0]});
        rd16(10'h060, v1);
        chk("count after status", 16'h1, {15'h0, v1 <= v2 && v1 + 16'h8 >= v2});
        cd_host_model_i.wr(CMD, 16'h00ec);
        cd_host_model_i.rd(10'h068, d);
        chk("second status", 16'hd4, {8'h0, d});
        cd_host_model_i.rd(10'h070, d);
        chk("third status", 16'h00, {8'h0, d});
    endtask : testReadBack
    task automatic testDecimal();
        logic [7:0] d;
        // a stray low byte before the second control word must be forgotten
        cd_host_model_i.wr(CMD, 16'h0075);
        cd_host_model_i.wr(10'h068, 16'h0099);
        cd_host_model_i.wr(CMD, 16'h0075);
        cd_host_model_i.wr(10'h068, 16'h0000);
        cd_host_model_i.wr(10'h068, 16'h0010);
        repeat (200)
        begin
            cd_host_model_i.rd(ST, d);
            if (d[5] === 1'b0)
                break;
        end
        // one tick past the load: decimal 1000 steps to 0999
        repeat (300) @(posedge clk);
        cd_host_model_i.wr(CMD, 16'h0040);
        rd16(10'h068, v1);
        chk("decimal count", 16'h0999, v1);
    endtask : testDecimal
    task automatic testModes();
        logic [7:0] d;
        logic [7:0] cw;
        for (int i = 0; i < 12; i++)
        begin
            cw = {2'h2, 2'((i % 3) + 1), 3'(i / 2), 1'(i)};
            cd_host_model_i.wr(CMD, {8'h0, cw});
            cd_host_model_i.wr(CMD, 16'h00e8);
            cd_host_model_i.rd(10'h070, d);
            chk("mode status", {8'h0, cw[3:1] != 3'h0, 1'b1, cw[5:0]}, {8'h0, d});
        end
    endtask : testModes
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        numErrors++;
        printVerdict();
    end
    initial
    begin
        reset = 1'b1;
        gatePin = 3'h0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        // gates open; a closed gate freezes counting outside the hardware-trigger modes
        gatePin <= 3'h7;
        testInit();
        testLatch();
        testReadBack();
        testDecimal();
        testModes();
        printVerdict();
    end
endmodule : cd_command_decoder_tb
`default_nettype wire

// ---- tb/cd_host_model.sv ----
`default_nettype none
module cd_host_model
(
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [31:0] datIn,
    output var  logic        cyc,
    output var  logic        stb,
    output var  logic        we,
    output var  logic [9:0]  adr,
    output var  logic [3:0]  sel,
    output var  logic [31:0] datOut
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {cyc, stb, we, adr, sel, datOut} = '0;
    end
    // 16-bit payload only matters for the divider; sel covers both bytes
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= 1'b1;
        adr <= a;
        sel <= 4'h3;
        datOut <= {16'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= 1'b0;
        adr <= a;
        sel <= 4'h1;
        do @(posedge clk); while (ack !== 1'b1);
        d = datIn[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : rd
    task automatic init();
        wr(10'h078, 16'h0014);
        wr(10'h078, 16'h0054);
    endtask : init
endmodule : cd_host_model
`default_nettype wire
